// ===== pkg/dcl_pkg.sv
// Purpose: shared constants and types for the clock change and leveling
//          sequencer
// Assumes: 32-bit classic Wishbone register port
// Notes:   timing counts are in clk_i cycles and programmable
package dcl_pkg;
  localparam int CNT_W = 16;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_MR0 = 8'h08;
  localparam logic [7:0] OFS_MR1 = 8'h0c;
  localparam logic [7:0] OFS_MR2 = 8'h10;
  localparam logic [7:0] OFS_TIM0 = 8'h14;
  localparam logic [7:0] OFS_TIM1 = 8'h18;
  localparam logic [7:0] OFS_TIM2 = 8'h1c;
  localparam logic [7:0] OFS_TIM3 = 8'h20;
  localparam logic [7:0] OFS_LEVEL = 8'h24;

  // control fields
  localparam int CTRL_FC_GO = 0;
  localparam int CTRL_WL_GO = 1;
  localparam int CTRL_PPD = 4;
  localparam int CTRL_BELOW = 5;
  localparam int CTRL_UPPER = 6;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0070;

  // status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_REFUSED = 1;
  localparam int STAT_FC_DONE = 2;
  localparam int STAT_WL_OK = 3;
  localparam int STAT_WL_FAIL = 4;
  localparam int STAT_CLK_CHG = 5;
  localparam int LEVEL_FB = 16;

  // timing fields: low and high half of each timing word
  localparam int TIM_HI = 16;

  // mode register bits, as masks on the address bus, and mode register selects on the bank address
  localparam logic [15:0] MR0_DLL_RST_M = 16'h0100;
  localparam logic [15:0] MR1_DLL_OFF_M = 16'h0001;
  localparam logic [15:0] MR1_WL_M = 16'h0080;
  localparam logic [2:0] BA_MR0 = 3'h0;
  localparam logic [2:0] BA_MR1 = 3'h1;
  localparam logic [2:0] BA_MR2 = 3'h2;

  // {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;

  // feedback bit of each byte lane
  localparam int DQ_LOWER = 0;
  localparam int DQ_UPPER = 8;

  // reset values
  localparam logic [15:0] MR_RST = 16'h0000;
  localparam logic [31:0] TIM0_RST = 32'h0010_0008;
  localparam logic [31:0] TIM1_RST = 32'h0080_0008;
  localparam logic [31:0] TIM2_RST = 32'h0200_0010;
  localparam logic [31:0] TIM3_RST = 32'h0008_0008;

  typedef enum logic [12:0] {
    ST_IDLE = 13'h0001,
    ST_DOFF = 13'h0002,
    ST_HOLD = 13'h0004,
    ST_CHG = 13'h0008,
    ST_STAB = 13'h0010,
    ST_XWAIT = 13'h0020,
    ST_MWAIT = 13'h0040,
    ST_DLLK = 13'h0080,
    ST_WL_WAIT = 13'h0100,
    ST_WL_ODT = 13'h0200,
    ST_WL_SAMP = 13'h0400,
    ST_WL_OFF = 13'h0800,
    ST_WL_END = 13'h1000
  } dcl_state_t;

  function automatic logic [31:0] dcl_merge(input logic [31:0] old,
                                            input logic [31:0] din,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = din[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage

// ===== src/dcl_ctrl.sv
// Purpose: host sequencer for clock frequency change and write leveling
// Assumes: device initialised and idle with cke high at reset release
// Notes:   software sets mode values and timings, then writes a go bit
// Operation
// (R1) clock held fixed outside change windows
// (R2) clock change only in self-refresh or power-down
// (R3) wait hold time, stable clock before exit
// (R4) keep full self-refresh entry and exit timing
// (R5) below minimum needs DLL-off first
// (R6) termination low through power-down change
// (R7) wait hold time after cke falls
// (R8) termination and cke low while changing
// (R9) stable clock for stable time before exit
// (R10) after exit time, reset DLL by MRS
// (R11) relock: termination low, cke high
// (R12) termination off and outputs idle first
// (R13) device returns clock sample on data
// (R14) step strobe delay until feedback rises
// (R15) adjustable delay on data strobe output
// (R16) strobe terminated at device, data here
// (R17) each byte lane leveled on own bit
// (R18) strobe duty cycle helps setup and hold
// (R19) MR1 bit 7 enters or leaves leveling
// (R20) MR0 bit 8 starts DLL reset
// (R21) only NOP or MR1 writes while leveling
// (R22) intervals timed by loaded counters
// (R23) track state, refuse illegal change requests
//
// The placing of the registers and register access over Wishbone were left to the implementer.
module dcl_ctrl import dcl_pkg::*; #(
  parameter int DLY_W = 6,
  parameter int DQ_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic cke_o,
  output logic odt_o,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [2:0] ba_o,
  output logic [15:0] addr_o,
  output logic clk_chg_o,
  input wire logic clk_stable_i,
  output logic [DLY_W-1:0] dqs_dly_o,
  output logic dqs_oe_o,
  output logic dqs_pulse_o,
  output logic dq_term_o,
  input wire logic [DQ_W-1:0] dq_i
);
  logic [31:0] ctrl, next_ctrl;
  logic [15:0] mr0, next_mr0, mr1, next_mr1, mr2, next_mr2;
  logic [31:0] tim0, next_tim0, tim1, next_tim1;
  logic [31:0] tim2, next_tim2, tim3, next_tim3;
  logic refused, next_refused, fc_done, next_fc_done;
  logic wl_ok, next_wl_ok, wl_fail, next_wl_fail;
  logic ack, next_ack;
  logic [31:0] dat, next_dat;
  logic wr_req, rd_req, fc_go, wl_go, busy;
  logic [7:0] adr;
  logic [31:0] w1c;
  logic set_refused, set_fc_done, set_wl_ok, set_wl_fail;

  dcl_state_t state, next_state;
  logic cke, next_cke, odt, next_odt, dqs_oe, next_dqs_oe;
  logic pulse, next_pulse, fbp, next_fbp;
  logic dll_off, next_dll_off, sr, next_sr;
  logic [3:0] cmd, next_cmd;
  logic [2:0] ba, next_ba;
  logic [15:0] addr, next_addr;
  logic [DLY_W-1:0] dly, next_dly;
  logic tmr_load, tmr_done;
  logic [CNT_W-1:0] tmr_val;
  logic fb, wl_lock, wl_end, ppd, below;

  assign adr = {wb_adr_i[7:2], 2'b00};
  assign wr_req = wb_cyc_i & wb_stb_i & wb_we_i & ~ack;
  assign rd_req = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack;
  assign fc_go = wr_req & (adr == OFS_CTRL) & wb_sel_i[0]
                 & wb_dat_i[CTRL_FC_GO];
  assign wl_go = wr_req & (adr == OFS_CTRL) & wb_sel_i[0]
                 & wb_dat_i[CTRL_WL_GO];
  assign w1c = (wr_req & (adr == OFS_STAT)) ? wb_dat_i : 32'h0000_0000;
  assign busy = (state != ST_IDLE);
  assign ppd = next_ctrl[CTRL_PPD];
  assign below = next_ctrl[CTRL_BELOW];

  // register file; settings are frozen while a sequence runs
  always_comb begin
    next_ctrl = ctrl;
    next_mr0 = mr0;
    next_mr1 = mr1;
    next_mr2 = mr2;
    next_tim0 = tim0;
    next_tim1 = tim1;
    next_tim2 = tim2;
    next_tim3 = tim3;
    next_ack = wb_cyc_i & wb_stb_i & ~ack;
    next_dat = dat;
    if (wr_req && !busy) begin
      case (adr)
        OFS_CTRL: next_ctrl = dcl_merge(ctrl, wb_dat_i, wb_sel_i) & CTRL_MASK;
        OFS_MR0: next_mr0 = 16'(dcl_merge({16'h0000, mr0}, wb_dat_i,
                                      wb_sel_i));
        OFS_MR1: next_mr1 = 16'(dcl_merge({16'h0000, mr1}, wb_dat_i,
                                      wb_sel_i));
        OFS_MR2: next_mr2 = 16'(dcl_merge({16'h0000, mr2}, wb_dat_i,
                                      wb_sel_i));
        OFS_TIM0: next_tim0 = dcl_merge(tim0, wb_dat_i, wb_sel_i);
        OFS_TIM1: next_tim1 = dcl_merge(tim1, wb_dat_i, wb_sel_i);
        OFS_TIM2: next_tim2 = dcl_merge(tim2, wb_dat_i, wb_sel_i);
        OFS_TIM3: next_tim3 = dcl_merge(tim3, wb_dat_i, wb_sel_i);
        default: next_ctrl = ctrl;
      endcase
    end
    if (rd_req) begin
      case (adr)
        OFS_CTRL: next_dat = ctrl;
        OFS_STAT: next_dat = {26'h000_0000, clk_chg_o, wl_fail, wl_ok,
                              fc_done, refused, busy};
        OFS_MR0: next_dat = {16'h0000, mr0};
        OFS_MR1: next_dat = {16'h0000, mr1};
        OFS_MR2: next_dat = {16'h0000, mr2};
        OFS_TIM0: next_dat = tim0;
        OFS_TIM1: next_dat = tim1;
        OFS_TIM2: next_dat = tim2;
        OFS_TIM3: next_dat = tim3;
        OFS_LEVEL: next_dat = {15'h0000, fbp, {(16-DLY_W){1'b0}}, dly};
        default: next_dat = 32'h0000_0000;
      endcase
    end
    // sticky flags: a new event wins over a clear
    next_refused = (refused & ~w1c[STAT_REFUSED]) | set_refused;
    next_fc_done = (fc_done & ~w1c[STAT_FC_DONE]) | set_fc_done;
    next_wl_ok = (wl_ok & ~w1c[STAT_WL_OK]) | set_wl_ok;
    next_wl_fail = (wl_fail & ~w1c[STAT_WL_FAIL]) | set_wl_fail;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= 32'h0000_0000;
      mr0 <= MR_RST;
      mr1 <= MR_RST;
      mr2 <= MR_RST;
      tim0 <= TIM0_RST;
      tim1 <= TIM1_RST;
      tim2 <= TIM2_RST;
      tim3 <= TIM3_RST;
      refused <= 1'b0;
      fc_done <= 1'b0;
      wl_ok <= 1'b0;
      wl_fail <= 1'b0;
      ack <= 1'b0;
      dat <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      mr0 <= next_mr0;
      mr1 <= next_mr1;
      mr2 <= next_mr2;
      tim0 <= next_tim0;
      tim1 <= next_tim1;
      tim2 <= next_tim2;
      tim3 <= next_tim3;
      refused <= next_refused;
      fc_done <= next_fc_done;
      wl_ok <= next_wl_ok;
      wl_fail <= next_wl_fail;
      ack <= next_ack;
      dat <= next_dat;
    end
  end

  dcl_timer #(.W(CNT_W)) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(tmr_load),
    .value_i(tmr_val),
    .done_o(tmr_done)
  );

  assign fb = ctrl[CTRL_UPPER] ? dq_i[DQ_UPPER] : dq_i[DQ_LOWER]; // R17 R13
  assign wl_lock = ~fbp & fb; // R14
  assign wl_end = wl_lock | (dly == {DLY_W{1'b1}});

  // sequencer: commands are issued on the transition out of idle on a go bit or out of a wait
  always_comb begin
    next_state = state;
    next_cke = cke;
    next_odt = odt;
    next_cmd = CMD_NOP;
    next_ba = ba;
    next_addr = addr;
    next_dly = dly;
    next_fbp = fbp;
    next_dqs_oe = dqs_oe;
    next_pulse = 1'b0;
    next_dll_off = dll_off;
    next_sr = sr;
    tmr_load = 1'b0;
    tmr_val = tim2[CNT_W-1:0];
    set_refused = ((fc_go | wl_go) & busy) | (fc_go & wl_go); // R23
    set_fc_done = 1'b0;
    set_wl_ok = 1'b0;
    set_wl_fail = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (fc_go && ppd && below) begin
          set_refused = 1'b1; // R5 R23
        end else if (fc_go) begin
          next_sr = ~ppd;
          next_dll_off = below;
          tmr_load = 1'b1;
          if (below) begin
            next_cmd = CMD_MRS; // R5
            next_ba = BA_MR1;
            next_addr = mr1 | MR1_DLL_OFF_M;
            next_state = ST_DOFF;
          end else begin
            next_cke = 1'b0; // R2 R6 R12
            next_cmd = ppd ? CMD_NOP : CMD_REF;
            tmr_val = tim0[CNT_W-1:0];
            next_state = ST_HOLD;
          end
        end else if (wl_go) begin
          next_cmd = CMD_MRS; // R19
          next_ba = BA_MR1;
          next_addr = mr1 | MR1_WL_M;
          next_dly = '0;
          next_fbp = 1'b1;
          tmr_load = 1'b1;
          next_state = ST_WL_WAIT;
        end
      end
      ST_DOFF: begin
        if (tmr_done) begin
          next_cke = 1'b0; // R4
          next_cmd = CMD_REF;
          tmr_load = 1'b1;
          tmr_val = tim0[CNT_W-1:0];
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (tmr_done) begin
          next_state = ST_CHG; // R3 R7 R22
        end
      end
      ST_CHG: begin
        if (clk_stable_i) begin
          tmr_load = 1'b1; // R9
          tmr_val = tim0[TIM_HI +: CNT_W];
          next_state = ST_STAB;
        end
      end
      ST_STAB: begin
        if (tmr_done) begin
          next_cke = 1'b1; // R3 R4 R9
          tmr_load = 1'b1;
          tmr_val = sr ? tim1[TIM_HI +: CNT_W] : tim1[CNT_W-1:0];
          next_state = ST_XWAIT;
        end
      end
      ST_XWAIT: begin
        if (tmr_done) begin
          next_cmd = CMD_MRS; // R10
          next_ba = BA_MR2;
          next_addr = mr2;
          tmr_load = 1'b1;
          next_state = ST_MWAIT;
        end
      end
      ST_MWAIT: begin
        if (tmr_done && dll_off) begin
          set_fc_done = 1'b1;
          next_state = ST_IDLE;
        end else if (tmr_done) begin
          next_cmd = CMD_MRS; // R10 R20
          next_ba = BA_MR0;
          next_addr = mr0 | MR0_DLL_RST_M;
          tmr_load = 1'b1;
          tmr_val = tim2[TIM_HI +: CNT_W];
          next_state = ST_DLLK;
        end
      end
      ST_DLLK: begin
        if (tmr_done) begin
          set_fc_done = 1'b1; // R11
          next_state = ST_IDLE;
        end
      end
      ST_WL_WAIT: begin
        if (tmr_done) begin
          next_odt = 1'b1; // R16
          next_dqs_oe = 1'b1;
          tmr_load = 1'b1;
          tmr_val = tim3[TIM_HI +: CNT_W];
          next_state = ST_WL_ODT;
        end
      end
      ST_WL_ODT: begin
        if (tmr_done) begin
          next_pulse = 1'b1; // R15 R18
          tmr_load = 1'b1;
          tmr_val = tim3[CNT_W-1:0];
          next_state = ST_WL_SAMP;
        end
      end
      ST_WL_SAMP: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_val = tim3[TIM_HI +: CNT_W];
          next_fbp = fb;
          if (wl_end) begin
            set_wl_ok = wl_lock; // R14
            set_wl_fail = ~wl_lock;
            next_odt = 1'b0;
            next_dqs_oe = 1'b0;
            next_state = ST_WL_OFF;
          end else begin
            next_dly = dly + 1'b1; // R14 R15
            next_state = ST_WL_ODT;
          end
        end
      end
      ST_WL_OFF: begin
        if (tmr_done) begin
          next_cmd = CMD_MRS; // R19 R21
          next_ba = BA_MR1;
          next_addr = mr1 & ~MR1_WL_M;
          tmr_load = 1'b1;
          next_state = ST_WL_END;
        end
      end
      ST_WL_END: begin
        if (tmr_done) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      cke <= 1'b1;
      odt <= 1'b0;
      cmd <= CMD_NOP;
      ba <= 3'h0;
      addr <= 16'h0000;
      dly <= '0;
      fbp <= 1'b1;
      dqs_oe <= 1'b0;
      pulse <= 1'b0;
      dll_off <= 1'b0;
      sr <= 1'b0;
    end else begin
      state <= next_state;
      cke <= next_cke;
      odt <= next_odt;
      cmd <= next_cmd;
      ba <= next_ba;
      addr <= next_addr;
      dly <= next_dly;
      fbp <= next_fbp;
      dqs_oe <= next_dqs_oe;
      pulse <= next_pulse;
      dll_off <= next_dll_off;
      sr <= next_sr;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = dat;
  assign cke_o = cke;
  assign odt_o = odt;
  assign {cs_n_o, ras_n_o, cas_n_o, we_n_o} = cmd;
  assign ba_o = ba;
  assign addr_o = addr;
  assign clk_chg_o = (state == ST_CHG); // R1
  assign dqs_dly_o = dly;
  assign dqs_oe_o = dqs_oe;
  assign dqs_pulse_o = pulse;
  assign dq_term_o = (state == ST_WL_ODT) || (state == ST_WL_SAMP); // R16

  chg_pins_a: assert property ( // R8
    @(posedge clk_i) disable iff (rst_i)
    state == ST_CHG |-> !cke && !odt)
    else $error("cke or odt high during clock change");
  chg_state_a: assert property ( // R2
    @(posedge clk_i) disable iff (rst_i)
    clk_chg_o |-> !cke && ($past(state) == ST_HOLD || $past(state) == ST_CHG))
    else $error("clock change outside low power state");
  chg_hold_a: assert property ( // R7
    @(posedge clk_i) disable iff (rst_i)
    $rose(clk_chg_o) |-> $past(tmr_done) && !$past(cke, 2))
    else $error("clock change before hold time");
  exit_stab_a: assert property ( // R9
    @(posedge clk_i) disable iff (rst_i)
    $rose(cke) |-> $past(state) == ST_STAB && $past(tmr_done))
    else $error("exit before stable clock time");
  dll_reset_a: assert property ( // R10 R20
    @(posedge clk_i) disable iff (rst_i)
    state == ST_MWAIT && tmr_done && !dll_off |=>
      cmd == CMD_MRS && ba == BA_MR0 && (addr & MR0_DLL_RST_M) != 16'h0000)
    else $error("missing dll reset write");
  relock_pins_a: assert property ( // R11
    @(posedge clk_i) disable iff (rst_i)
    state == ST_DLLK |-> cke && !odt)
    else $error("pins wrong during relock");
  wl_cmd_a: assert property ( // R21
    @(posedge clk_i) disable iff (rst_i)
    (state == ST_WL_WAIT || state == ST_WL_ODT || state == ST_WL_SAMP ||
     state == ST_WL_OFF || state == ST_WL_END) && cmd != CMD_NOP |->
      cmd == CMD_MRS && ba == BA_MR1)
    else $error("illegal command while leveling");
  refuse_req_a: assert property ( // R23
    @(posedge clk_i) disable iff (rst_i)
    state == ST_IDLE && fc_go && ppd && below |=>
      refused && state == ST_IDLE && cke)
    else $error("illegal change request not refused");
  wl_lock_a: assert property ( // R14
    @(posedge clk_i) disable iff (rst_i)
    $rose(wl_ok) |-> state == ST_WL_OFF && $stable(dqs_dly_o) && !dqs_oe_o)
    else $error("delay not held on lock");
  dqs_term_a: assert property ( // R16
    @(posedge clk_i) disable iff (rst_i)
    dqs_pulse_o |-> dqs_oe_o && odt_o && dq_term_o)
    else $error("strobe pulse without termination");
endmodule

// ===== src/dcl_timer.sv
// Purpose: interval counter for the sequencer
// Assumes: value_i of at least one cycle
// Notes:   done_o is high while the count stands at zero
module dcl_timer import dcl_pkg::*; #(
  parameter int W = CNT_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  output logic done_o
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  // load wins over counting down
  always_comb begin
    next_cnt = cnt;
    if (load_i) begin
      next_cnt = value_i; // R22
    end else if (cnt != '0) begin
      next_cnt = cnt - 1'b1; // R22
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign done_o = (cnt == '0);
endmodule

// ===== verification/dcl_ctrl_tb.sv
// Purpose: self-checking bench for the clock change and leveling sequencer
// Assumes: dram model answers on the far side
// Notes:   timings are programmed small to keep the run short
`define CHK(w, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
  fail_count++; $display("BAD %s exp %0h got %0h", w, ex, got); end end
module dcl_ctrl_tb import dcl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack_o, stuck, clk_stable;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat, wb_dat_o;
  logic cke_o, odt_o, cs_n_o, ras_n_o, cas_n_o, we_n_o, clk_chg_o;
  logic [2:0] ba_o;
  logic [15:0] addr_o, dq;
  logic [5:0] dqs_dly_o;
  logic dqs_oe_o, dqs_pulse_o, dq_term_o;
  int fail_count, checks_done, cycles, err, n0;
  dcl_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cke_o(cke_o), .odt_o(odt_o), .cs_n_o(cs_n_o), .ras_n_o(ras_n_o),
    .cas_n_o(cas_n_o), .we_n_o(we_n_o), .ba_o(ba_o), .addr_o(addr_o),
    .clk_chg_o(clk_chg_o), .clk_stable_i(clk_stable), .dqs_dly_o(dqs_dly_o),
    .dqs_oe_o(dqs_oe_o), .dqs_pulse_o(dqs_pulse_o), .dq_term_o(dq_term_o),
    .dq_i(dq));
  dcl_dram_model i_mem (.clk_i(clk_i), .rst_i(rst_i), .cke_i(cke_o),
    .odt_i(odt_o), .cmd_i({cs_n_o, ras_n_o, cas_n_o, we_n_o}), .ba_i(ba_o),
    .addr_i(addr_o), .clk_chg_i(clk_chg_o), .dly_i(dqs_dly_o),
    .dqs_oe_i(dqs_oe_o), .dqs_pulse_i(dqs_pulse_o), .dq_term_i(dq_term_o),
    .stuck_i(stuck), .clk_stable_o(clk_stable), .dq_o(dq), .err_o(err));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= s;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    `CHK("ack", 1'b1, wb_ack_o);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hf, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0000_0000, 4'hf, q);
  endtask
  task automatic wait_idle();
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      rd(OFS_STAT, q);
      n++;
    end while (q[STAT_BUSY] !== 1'b0 && n < 1000);
    `CHK("idle", 1'b0, q[STAT_BUSY]);
  endtask
  task automatic go(input logic [31:0] c, input logic busy);
    logic [31:0] q;
    n0 = i_mem.nlog;
    wr(OFS_CTRL, c);
    rd(OFS_STAT, q);
    `CHK("busy", busy, q[STAT_BUSY]);
    wait_idle();
  endtask
  task automatic t_reset();
    logic [7:0] a [11];
    logic [31:0] e [11];
    logic [31:0] q;
    a = '{OFS_CTRL, OFS_STAT, OFS_MR0, OFS_MR1, OFS_MR2, OFS_TIM0,
          OFS_TIM1, OFS_TIM2, OFS_TIM3, OFS_LEVEL, 8'h28};
    e = '{32'h0000_0000, 32'h0000_0000, {16'h0000, MR_RST},
          {16'h0000, MR_RST}, {16'h0000, MR_RST}, TIM0_RST, TIM1_RST,
          TIM2_RST, TIM3_RST, 32'h0001_0000, 32'h0000_0000};
    for (int i = 0; i < 11; i++) begin
      rd(a[i], q);
      `CHK("reset reg", e[i], q);
    end
    `CHK("cke", 1'b1, cke_o);
    `CHK("chg", 1'b0, clk_chg_o);
    $display("t_reset done");
  endtask
  task automatic t_regs();
    logic [31:0] q;
    wb(1'b1, OFS_TIM0, 32'hffff_ffff, 4'h1, q);
    rd(OFS_TIM0, q);
    `CHK("merge", 32'h0010_00ff, q);
    wr(OFS_TIM0, 32'h0004_0003);
    wr(OFS_TIM1, 32'h0006_0003);
    wr(OFS_TIM2, 32'h0005_0002);
    wr(OFS_TIM3, 32'h0002_0002);
    wr(OFS_MR0, 32'h0000_0420);
    wr(OFS_MR1, 32'h0000_0004);
    wr(OFS_MR2, 32'h0000_0018);
    rd(OFS_TIM2, q);
    `CHK("tim2", 32'h0005_0002, q);
    wr(OFS_CTRL, 32'h0000_00fc);
    rd(OFS_CTRL, q);
    `CHK("ctrl", CTRL_MASK, q);
    wr(OFS_CTRL, 32'h0000_0000);
    $display("t_regs done");
  endtask
  task automatic t_fc_sr();
    logic [31:0] q;
    go(32'h0000_0001, 1'b1);
    `CHK("count", 3, i_mem.nlog - n0);
    `CHK("sre", CMD_REF, i_mem.lcmd[n0]);
    `CHK("mr2 ba", BA_MR2, i_mem.lba[n0+1]);
    `CHK("mr2", 16'h0018, i_mem.ladr[n0+1]);
    `CHK("mr0 ba", BA_MR0, i_mem.lba[n0+2]);
    `CHK("dll rst", 16'h0520, i_mem.ladr[n0+2]);
    `CHK("hold", 1'b1, i_mem.t_chg - i_mem.t_ckef >= 4);
    `CHK("stable", 1'b1, i_mem.t_ckr - i_mem.t_stb >= 4);
    `CHK("txs", 1'b1, i_mem.ltim[n0+1] - i_mem.t_ckr >= 6);
    `CHK("tmod", 1'b1, i_mem.ltim[n0+2] - i_mem.ltim[n0+1] >= 2);
    rd(OFS_STAT, q);
    `CHK("done", 1'b1, q[STAT_FC_DONE]);
    `CHK("cke up", 1'b1, cke_o);
    wr(OFS_STAT, 32'h0000_001e);
    $display("t_fc_sr done");
  endtask
  task automatic t_fc_ppd();
    go(32'h0000_0011, 1'b1);
    `CHK("count", 2, i_mem.nlog - n0);
    `CHK("dll rst", 16'h0520, i_mem.ladr[n0+1]);
    `CHK("hold", 1'b1, i_mem.t_chg - i_mem.t_ckef >= 4);
    `CHK("stable", 1'b1, i_mem.t_ckr - i_mem.t_stb >= 4);
    `CHK("txp", 1'b1, i_mem.ltim[n0] - i_mem.t_ckr >= 3);
    `CHK("slips", 0, err);
    $display("t_fc_ppd done");
  endtask
  task automatic t_fc_below();
    go(32'h0000_0021, 1'b1);
    `CHK("count", 3, i_mem.nlog - n0);
    `CHK("dll off", 16'h0005, i_mem.ladr[n0]);
    `CHK("dll ba", BA_MR1, i_mem.lba[n0]);
    `CHK("sre", CMD_REF, i_mem.lcmd[n0+1]);
    `CHK("tmod", 1'b1, i_mem.ltim[n0+1] - i_mem.ltim[n0] >= 2);
    $display("t_fc_below done");
  endtask
  task automatic t_refuse();
    logic [31:0] q;
    go(32'h0000_0031, 1'b0);
    rd(OFS_STAT, q);
    `CHK("refused", 1'b1, q[STAT_REFUSED]);
    `CHK("no cmd", 0, i_mem.nlog - n0);
    n0 = i_mem.nlog;
    wr(OFS_CTRL, 32'h0000_0003);
    wr(OFS_TIM0, 32'h0009_0009);
    wr(OFS_CTRL, 32'h0000_0001);
    wait_idle();
    rd(OFS_TIM0, q);
    `CHK("tim kept", 32'h0004_0003, q);
    `CHK("fc taken", CMD_REF, i_mem.lcmd[n0]);
    wr(OFS_STAT, 32'h0000_001e);
    rd(OFS_STAT, q);
    `CHK("cleared", 32'h0000_0000, q);
    $display("t_refuse done");
  endtask
  task automatic wl_run(input logic [31:0] c, input logic [5:0] tap,
                        input int bit_no);
    logic [31:0] q;
    go(c, 1'b1);
    rd(OFS_STAT, q);
    `CHK("outcome", 1'b1, q[bit_no]);
    rd(OFS_LEVEL, q);
    `CHK("tap", tap, q[5:0]);
    `CHK("dly", tap, dqs_dly_o);
    `CHK("enter", BA_MR1, i_mem.lba[n0]);
    `CHK("enter mr1", 16'h0084, i_mem.ladr[n0]);
    `CHK("exit mr1", 16'h0004, i_mem.ladr[n0+1]);
    `CHK("count", 2, i_mem.nlog - n0);
    `CHK("odt off", 1'b0, odt_o);
    `CHK("slips", 0, err);
    wr(OFS_STAT, 32'h0000_001e);
  endtask
  task automatic t_wl_lower();
    logic [31:0] q;
    wl_run(32'h0000_0002, 6'h05, STAT_WL_OK);
    rd(OFS_LEVEL, q);
    `CHK("last fb", 1'b1, q[LEVEL_FB]);
    $display("t_wl_lower done");
  endtask
  task automatic t_wl_upper();
    wl_run(32'h0000_0042, 6'h09, STAT_WL_OK);
    $display("t_wl_upper done");
  endtask
  task automatic t_wl_fail();
    stuck <= 1'b1;
    wl_run(32'h0000_0002, 6'h3f, STAT_WL_FAIL);
    stuck <= 1'b0;
    $display("t_wl_fail done");
  endtask
  initial begin
    rst_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat = 32'h0000_0000;
    stuck = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_fc_sr();
    t_fc_ppd();
    t_fc_below();
    t_refuse();
    t_wl_lower();
    t_wl_upper();
    t_wl_fail();
    `CHK("final slips", 0, err);
    give_verdict();
  end
endmodule

// ===== verification/dcl_dram_model.sv
// Purpose: behavioural DRAM seen from the sequencer's pins
// Assumes: commands sampled on rising clk_i; clock generator modelled here
// Notes:   err_o counts controller slips; lcmd/lba/ladr/ltim log commands
module dcl_dram_model import dcl_pkg::*; #(
  parameter int LOCK_LO = 5,
  parameter int LOCK_HI = 9,
  parameter int STB_DLY = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cke_i,
  input wire logic odt_i,
  input wire logic [3:0] cmd_i,
  input wire logic [2:0] ba_i,
  input wire logic [15:0] addr_i,
  input wire logic clk_chg_i,
  input wire logic [5:0] dly_i,
  input wire logic dqs_oe_i,
  input wire logic dqs_pulse_i,
  input wire logic dq_term_i,
  input wire logic stuck_i,
  output logic clk_stable_o,
  output logic [15:0] dq_o,
  output int err_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wl, fb_lo, fb_hi, cke_q, chg_q;
  logic [15:0] pat;
  int cnt, cyc, nlog, t_ckef, t_ckr, t_chg, t_stb;
  logic [3:0] lcmd [32];
  logic [2:0] lba [32];
  logic [15:0] ladr [32];
  int ltim [32];
  assign clk_stable_o = chg_q && (cnt == STB_DLY);
  // unterminated dq is not trusted: it toggles every cycle
  assign dq_o = (wl && dq_term_i) ? {7'h00, fb_hi, 7'h00, fb_lo} : pat;
  always @(posedge clk_i) begin
    int e;
    e = 0;
    cyc <= cyc + 1;
    pat <= ~pat;
    cke_q <= cke_i;
    chg_q <= clk_chg_i;
    if (rst_i) begin
      wl <= 1'b0;
      fb_lo <= 1'b0;
      fb_hi <= 1'b0;
      cnt <= STB_DLY;
      err_o <= 0;
      nlog <= 0;
      cyc <= 0;
      pat <= 16'h5a5a;
    end else begin
      // clock is ignored once cke low, new clock settles after a delay
      if (clk_chg_i && !chg_q) begin
        cnt <= 0;
        t_chg <= cyc;
      end else if (cnt < STB_DLY) begin
        cnt <= cnt + 1;
      end
      if (cnt == STB_DLY - 1) t_stb <= cyc + 1;
      if (!cke_i && cke_q) t_ckef <= cyc;
      if (cke_i && !cke_q) t_ckr <= cyc;
      if (clk_chg_i && (cke_i || odt_i)) e++;
      if (odt_i && !wl) e++;
      if (cmd_i !== CMD_NOP) begin
        if (nlog < 32) begin
          lcmd[nlog] <= cmd_i;
          lba[nlog] <= ba_i;
          ladr[nlog] <= addr_i;
          ltim[nlog] <= cyc;
        end
        nlog <= nlog + 1;
        if (wl && !(cmd_i == CMD_MRS && ba_i == BA_MR1)) e++;
        if (cmd_i == CMD_MRS && ba_i == BA_MR1) wl <= addr_i[7];
      end
      if (dqs_pulse_i) begin
        fb_lo <= stuck_i || (dly_i >= LOCK_LO);
        fb_hi <= stuck_i || (dly_i >= LOCK_HI);
        if (!wl || !odt_i || !dqs_oe_i) e++;
      end
      err_o <= err_o + e;
    end
  end
endmodule
